// ==== bench/dma_channel_register_set_bench.sv ====
// Self-checking bench for the DMA register set and transfer sequencing.
`timescale 1ns/1ps
module dma_channel_register_set_bench
  import dma_regs_pkg::*;
();
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic [AW-1:0]     regAddr = '0;
  logic [DW-1:0]     regWdata = '0;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic [DW-1:0]     regRdata;
  logic [127:0]      irqLines = '0;
  logic [DW-1:0]     periphRdata;
  logic [DW-1:0]     ramRdata;
  logic              periphWriteCollision;
  logic              ramWriteCollision;
  logic              colPeriph = 1'b0;
  logic              colRam = 1'b0;
  bus_req_t          periphReq;
  bus_req_t          ramReq;
  logic [NUM_CH-1:0] channelIrqFlag;
  int                irqCnt [NUM_CH];
  int                mismatches = 0;
  int                total_checks = 0;
  int                c;
  int                pw;

  always #10 core_clk = ~core_clk;

  dma_channel_register_set #(.NCH(NUM_CH)) dma_channel_register_set_inst (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .irqLines(irqLines), .periphRdata(periphRdata),
    .periphWriteCollision(periphWriteCollision), .periphReq(periphReq),
    .ramRdata(ramRdata), .ramWriteCollision(ramWriteCollision),
    .ramReq(ramReq), .channelIrqFlag(channelIrqFlag));

  periph_ram_model periph_ram_model_inst (
    .core_clk(core_clk), .periphReq(periphReq), .ramReq(ramReq),
    .colPeriph(colPeriph), .colRam(colRam), .periphRdata(periphRdata),
    .ramRdata(ramRdata), .periphWriteCollision(periphWriteCollision),
    .ramWriteCollision(ramWriteCollision));

  always @(posedge core_clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (rst) irqCnt[i] <= 0;
      else if (channelIrqFlag[i] === 1'b1) irqCnt[i] <= irqCnt[i] + 1;
    end
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  function automatic logic [AW-1:0] ra(input int ch, input logic [AW-1:0] o);
    return AW'(ch) * CH_STRIDE + o;
  endfunction

  task automatic regWr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample there.
  task automatic rdChk(input logic [AW-1:0] a, input logic [DW-1:0] exp,
                       input string what);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    check(regRdata, exp, what);
  endtask

  // Addresses and count are written before the enable bit goes up.
  task automatic cfg(input int ch, input logic [DW-1:0] primary_buffer_base, stb, pad, cnt,
                     input logic [DW-1:0] con);
    regWr(ra(ch, OFF_PRI), primary_buffer_base);
    regWr(ra(ch, OFF_SEC), stb);
    regWr(ra(ch, OFF_PAD), pad);
    regWr(ra(ch, OFF_COUNT), cnt);
    regWr(ra(ch, OFF_CON), con);
  endtask

  task automatic waitXfer(input int n);
    for (int k = 0; k < 40 && periph_ram_model_inst.xfers < n; k++) begin
      @(posedge core_clk);
    end
    if (periph_ram_model_inst.xfers < n) begin
      mismatches++;
      $display("MISMATCH at %0t: transfer never completed", $time);
      end_of_test();
    end
    repeat (3) @(posedge core_clk);
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rdChk(ra(0, OFF_CON), 16'h0000, "control reset");
    rdChk(OFF_CS1, 16'h0F00, "status1 reset");
    rdChk(OFF_RADR, 16'h0000, "recent address reset");
    rdChk(OFF_CS0, 16'h0000, "collision reset");
    rdChk(ra(0, OFF_PRI), 16'h0000, "base reset");
    $display("Test reset values done");

    regWr(ra(3, OFF_CON), 16'h7FFF);
    rdChk(ra(3, OFF_CON), 16'h7833, "control fields");
    regWr(ra(3, OFF_REQ), 16'h7FFF);
    rdChk(ra(3, OFF_REQ), 16'h007F, "source select");
    regWr(ra(3, OFF_COUNT), 16'hFFFF);
    rdChk(ra(3, OFF_COUNT), 16'h03FF, "count width");
    regWr(ra(3, OFF_PRI), 16'h1234);
    rdChk(ra(3, OFF_PRI), 16'h0000, "base reads pointer");
    regWr(8'h7F, 16'hFFFF);
    rdChk(8'h7F, 16'h0000, "unmapped");
    rdChk(ra(3, 8'h06), 16'h0000, "hole");
    for (c = 0; c < NUM_CH; c++) regWr(ra(c, OFF_PAD), 16'h1000 + 16'(c));
    for (c = 0; c < NUM_CH; c++) begin
      rdChk(ra(c, OFF_PAD), 16'h1000 + 16'(c), "periph address");
    end
    regWr(ra(1, OFF_REQ), 16'h8000);
    regWr(ra(1, OFF_REQ), 16'h0000);
    rdChk(ra(1, OFF_REQ), 16'h8000, "force sticks");
    $display("Test register access done");

    cfg(0, 16'h0100, 16'h0000, 16'h0200, 16'h0001, 16'h8001);
    regWr(ra(0, OFF_REQ), 16'h8000);
    waitXfer(1);
    check(periph_ram_model_inst.ramAddrQ[$], 16'h0100, "ram addr");
    check(periph_ram_model_inst.lastRamData, 16'hA7A5, "ram data");
    rdChk(ra(0, OFF_REQ), 16'h0000, "force cleared");
    rdChk(OFF_CS1, 16'h0000, "last channel 0");
    rdChk(OFF_RADR, 16'h0100, "recent address");
    rdChk(ra(0, OFF_PRI), 16'h0102, "word step");
    check(16'(irqCnt[0]), 16'h0000, "no early irq");
    regWr(ra(0, OFF_REQ), 16'h8000);
    waitXfer(2);
    check(periph_ram_model_inst.ramAddrQ[$], 16'h0102, "ram addr 2");
    check(16'(irqCnt[0]), 16'h0001, "full irq");
    rdChk(ra(0, OFF_CON), 16'h0001, "one-shot off");
    $display("Test forced one-shot done");

    cfg(6, 16'h0300, 16'h0000, 16'h0210, 16'h0001, 16'h8001);
    cfg(7, 16'h0400, 16'h0000, 16'h0210, 16'h0001, 16'hC001);
    regWr(ra(6, OFF_REQ), 16'h007F);
    regWr(ra(7, OFF_REQ), 16'h007F);
    @(posedge core_clk);
    irqLines[127] <= 1'b1;
    repeat (2) @(posedge core_clk);
    irqLines[127] <= 1'b0;
    waitXfer(4);
    check(periph_ram_model_inst.ramAddrQ[2], 16'h0300, "first won");
    check(periph_ram_model_inst.ramAddrQ[3], 16'h0400, "second");
    check(16'(periph_ram_model_inst.lastRamByte), 16'h0001, "byte");
    rdChk(ra(6, OFF_PRI), 16'h0302, "word pointer");
    rdChk(ra(7, OFF_PRI), 16'h0401, "byte pointer");
    rdChk(OFF_CS1, 16'h0700, "last channel 7");
    $display("Test priority done");

    cfg(4, 16'h0500, 16'h0600, 16'h0220, 16'h0001, 16'hB002);
    regWr(ra(4, OFF_REQ), 16'h8000);
    waitXfer(5);
    check(periph_ram_model_inst.lastPerAddr, 16'h0220, "periph addr");
    check(periph_ram_model_inst.lastPerData, 16'h5F5A, "periph data");
    check(16'(irqCnt[4]), 16'h0001, "half irq");
    regWr(ra(4, OFF_REQ), 16'h8000);
    waitXfer(6);
    check(16'(irqCnt[4]), 16'h0001, "no full irq");
    rdChk(OFF_CS1, 16'h0410, "ping-pong status");
    rdChk(ra(4, OFF_PRI), 16'h0600, "secondary pointer");
    rdChk(ra(4, OFF_CON), 16'hB002, "continuous stays");
    $display("Test ping-pong done");

    pw = periph_ram_model_inst.perWrites;
    cfg(5, 16'h0700, 16'h0000, 16'h0230, 16'h0003, 16'h8811);
    colPeriph <= 1'b1;
    colRam <= 1'b1;
    regWr(ra(5, OFF_REQ), 16'h8000);
    waitXfer(7);
    colPeriph <= 1'b0;
    colRam <= 1'b0;
    check(16'(periph_ram_model_inst.perWrites - pw), 16'h0001, "null");
    check(periph_ram_model_inst.lastPerAddr, 16'h0230, "null addr");
    rdChk(ra(5, OFF_PRI), 16'h0700, "no increment");
    rdChk(OFF_RADR, 16'h0700, "recent address 2");
    rdChk(OFF_CS0, 16'h2020, "collisions");
    regWr(OFF_CS0, 16'hFFFF);
    rdChk(OFF_CS0, 16'h2020, "ones keep");
    regWr(OFF_CS0, 16'h0000);
    rdChk(OFF_CS0, 16'h0000, "zeros clear");
    regWr(OFF_CS1, 16'hFFFF);
    rdChk(OFF_CS1, 16'h0510, "status1 read-only");
    $display("Test null write and collisions done");

    // Peripheral indirect: RAM address is primary base plus peripheral data.
    cfg(2, 16'h0800, 16'h0900, 16'h0240, 16'h0000, 16'h8023);
    regWr(ra(2, OFF_REQ), 16'h8000);
    waitXfer(8);
    check(periph_ram_model_inst.ramAddrQ[$], 16'hAFE5, "indirect");
    rdChk(OFF_RADR, 16'hAFE5, "recent indirect");
    regWr(ra(2, OFF_REQ), 16'h8000);
    waitXfer(9);
    check(16'(irqCnt[2]), 16'h0002, "two blocks");
    rdChk(ra(2, OFF_CON), 16'h0023, "one-shot ping-pong off");
    rdChk(OFF_CS1, 16'h0210, "ping-pong back");
    $display("Test peripheral indirect done");
    end_of_test();
  end
endmodule // dma_channel_register_set_bench

// ==== bench/periph_ram_model.sv ====
// Behavioural peripheral bus and buffer RAM that answer the DMA block.
`timescale 1ns/1ps
module periph_ram_model
  import dma_regs_pkg::*;
(
  // Clock
  input  wire logic      core_clk,
  // Requests from the DMA block
  input  wire bus_req_t  periphReq,
  input  wire bus_req_t  ramReq,
  // Collision levels commanded by the bench
  input  wire logic      colPeriph,
  input  wire logic      colRam,
  // Answers
  output logic [DW-1:0]  periphRdata,
  output logic [DW-1:0]  ramRdata,
  output logic           periphWriteCollision,
  output logic           ramWriteCollision
);
  logic [DW-1:0] pHeld = '0;
  logic [DW-1:0] rHeld = '0;
  logic [DW-1:0] lastPerAddr;
  logic [DW-1:0] lastPerData;
  logic [DW-1:0] lastRamData;
  logic          lastRamByte;
  logic [DW-1:0] ramAddrQ[$];
  int            xfers = 0;
  int            perWrites = 0;
  logic          pRd;
  logic          rRd;

  assign pRd = periphReq.valid && !periphReq.write;
  assign rRd = ramReq.valid && !ramReq.write;
  // Data stands in the request cycle and the next one, then it is inverted
  // every cycle so that a sample two cycles late cannot match by luck.
  assign periphRdata = pRd ? (periphReq.addr ^ 16'hA5A5) : pHeld;
  assign ramRdata    = rRd ? (ramReq.addr ^ 16'h5A5A) : rHeld;
  assign periphWriteCollision = colPeriph;
  assign ramWriteCollision    = colRam;

  always @(posedge core_clk) begin
    pHeld <= pRd ? (periphReq.addr ^ 16'hA5A5) : ~pHeld;
    rHeld <= rRd ? (ramReq.addr ^ 16'h5A5A) : ~rHeld;
    if (ramReq.valid && ramReq.write) begin
      ramAddrQ.push_back(ramReq.addr);
      lastRamData <= ramReq.wdata;
      lastRamByte <= ramReq.byteSize;
    end
    if (periphReq.valid && periphReq.write) begin
      perWrites <= perWrites + 1;
      lastPerAddr <= periphReq.addr;
      lastPerData <= periphReq.wdata;
    end
    if ((ramReq.valid && ramReq.write) ||
        (periphReq.valid && periphReq.write)) begin
      xfers <= xfers + 1;
    end
  end
endmodule // periph_ram_model

// ==== pkg/dma_regs_pkg.sv ====
// Package: register map, field positions and carrier types of the DMA block.
package dma_regs_pkg;
  localparam int NUM_CH  = 8;
  localparam int DW      = 16;
  localparam int AW      = 8;
  // Per-channel block: eight words at CH_STRIDE, common registers above.
  localparam logic [AW-1:0] OFF_CON    = 8'h00;
  localparam logic [AW-1:0] OFF_REQ    = 8'h01;
  localparam logic [AW-1:0] OFF_PRI    = 8'h02;
  localparam logic [AW-1:0] OFF_SEC    = 8'h03;
  localparam logic [AW-1:0] OFF_PAD    = 8'h04;
  localparam logic [AW-1:0] OFF_COUNT  = 8'h05;
  localparam logic [AW-1:0] CH_STRIDE  = 8'h08;
  localparam logic [AW-1:0] OFF_CS0    = 8'h40;
  localparam logic [AW-1:0] OFF_CS1    = 8'h41;
  localparam logic [AW-1:0] OFF_RADR   = 8'h42;
  localparam int B_EN    = 15;
  localparam int B_SIZE  = 14;
  localparam int B_DIR   = 13;
  localparam int B_HALF  = 12;
  localparam int B_NULL  = 11;
  localparam int B_FORCE = 15;
  localparam logic [DW-1:0] CON_MASK = 16'hF833;
  localparam logic [DW-1:0] REQ_SEL_MASK = 16'h007F;
  localparam logic [DW-1:0] CNT_MASK = 16'h03FF;
  localparam logic [3:0]    LAST_NONE = 4'hF;
  localparam logic [1:0] AM_POSTINC = 2'h0;
  localparam logic [1:0] AM_NOINC   = 2'h1;
  localparam logic [DW-1:0] WORD_STEP = 16'h0002;
  localparam logic [DW-1:0] BYTE_STEP = 16'h0001;

  typedef struct packed {
    logic       enable;
    logic       byteSize;
    logic       toPeriph;
    logic       halfIrq;
    logic       nullWrite;
    logic [1:0] addrStyle;
    logic [1:0] opMode;
  } chan_ctrl_t;

  typedef struct packed {
    logic          valid;
    logic          write;
    logic          byteSize;
    logic [DW-1:0] addr;
    logic [DW-1:0] wdata;
  } bus_req_t;
endpackage

// ==== rtl/dma_channel_register_set.sv ====
// Eight-channel DMA engine: register set, arbitration and transfer sequencing.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// R1: Eight identical channels, each with six own registers.
// R2: Base registers store writes; reads return the working RAM pointer.
// R3: Control bit 15 enables the channel; resets to zero.
// R4: Control bit 14 selects byte transfers, else 16-bit words.
// R5: Control bit 13 set copies RAM to peripheral, clear the reverse.
// R6: Control bit 12 raises the channel interrupt at half block, else full.
// R7: Null-write bit adds a dummy peripheral write; direction bit stays clear.
// R8: Addressing: post-increment, no increment, peripheral indirect (11 too).
// R9: Mode bits choose continuous/one-shot, with or without ping-pong.
// R10: Force bit starts one transfer; only hardware clears it.
// R11: Seven-bit source select picks one of 128 request lines.
// R12: Primary and secondary 16-bit RAM start addresses, reset to zero.
// R13: Software avoids writing address or count registers while enabled.
// R14: Ten-bit count; a block is count plus one transfers.
// R15: Sixteen-bit peripheral address register per channel.
// R16: Peripheral write collision flags in status 0 high byte, clear only.
// R17: RAM write collision flags in status 0 low byte, clear only.
// R18: Last active channel reads 1111 until first transfer, then its number.
// R19: Ping-pong status bits show secondary (1) or primary (0) base.
// R20: Read-only register holds most recent RAM address accessed.
// R21: Each channel pulses an interrupt flag to the interrupt controller.
// R22: Simultaneous requests are granted by fixed channel priority.
// R23: Ping-pong switches between the two bases after every block.
// R24: Lower-numbered channel wins arbitration.
// R25: One-shot clears enable after final block; continuous reloads and stays.
module dma_channel_register_set
  import dma_regs_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // Register port
  input  wire logic [AW-1:0]        regAddr,
  input  wire logic [DW-1:0]        regWdata,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [DW-1:0]        regRdata,
  // Peripheral side
  input  wire logic [127:0]         irqLines,
  input  wire logic [DW-1:0]        periphRdata,
  input  wire logic                 periphWriteCollision,
  output bus_req_t                  periphReq,
  // Buffer RAM side
  input  wire logic [DW-1:0]        ramRdata,
  input  wire logic                 ramWriteCollision,
  output bus_req_t                  ramReq,
  // Interrupt flags
  output logic      [NCH-1:0]       channelIrqFlag
);
  chan_ctrl_t    ctrl_reg [NCH];
  logic [DW-1:0] primaryBase_reg [NCH];
  logic [DW-1:0] secondaryBase_reg [NCH];
  logic [DW-1:0] periphAddr_reg [NCH];
  logic [9:0]    count_reg [NCH];
  logic [6:0]    reqSel_reg [NCH];
  logic [NCH-1:0] force_reg;
  logic [DW-1:0] workAddr_reg [NCH];
  logic [9:0]    done_reg [NCH];
  logic [NCH-1:0] pingSel_reg;
  logic [NCH-1:0] secondBlock_reg;
  logic [NCH-1:0] pend_reg;
  logic [NCH-1:0] irqPrev_reg;
  logic [7:0]    peripheral_write_collision_reg;
  logic [7:0]    ram_write_collision_reg;
  logic [3:0]    lastCh_reg;
  logic [DW-1:0] recentRam_reg;
  logic [DW-1:0] rdata_next;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} xfer_state_t;
  xfer_state_t   state_reg;
  logic [2:0]    act_reg;

  function automatic logic [2:0] chOf(input logic [AW-1:0] a);
    return a[5:3];
  endfunction
  function automatic logic [AW-1:0] offOf(input logic [AW-1:0] a);
    return {5'h00, a[2:0]};
  endfunction
  function automatic logic [DW-1:0] stepOf(input logic b);
    return b ? BYTE_STEP : WORD_STEP;
  endfunction

  logic chSpace;
  assign chSpace = (regAddr < OFF_CS0);

  // A force write in the finishing cycle beats the hardware clear.
  logic forceWr;
  assign forceWr = regWrite && chSpace && offOf(regAddr) == OFF_REQ &&
                   regWdata[B_FORCE];

  // Edge of the selected request line marks one request; level would repeat.
  logic [NCH-1:0] reqNow;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      reqNow[c] = irqLines[reqSel_reg[c]];
    end
  end

  logic [NCH-1:0] ready;
  logic [2:0]     grant;
  logic           anyReady;
  always_comb begin
    grant = '0;
    anyReady = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      ready[c] = ctrl_reg[c].enable && (pend_reg[c] || force_reg[c]);
    end
    for (int c = NCH - 1; c >= 0; c--) begin
      if (ready[c]) begin
        grant = 3'(c); // R22 R24
        anyReady = 1'b1;
      end
    end
  end

  // End-of-transfer bookkeeping for the active channel.
  logic          finish;
  logic          blockEnd;
  logic          halfPoint;
  chan_ctrl_t    ac;
  assign finish    = (state_reg == ST_WRITE);
  assign ac        = ctrl_reg[act_reg];
  assign blockEnd  = finish && (done_reg[act_reg] == count_reg[act_reg]); // R14
  assign halfPoint = finish && (done_reg[act_reg] == (count_reg[act_reg] >> 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      act_reg   <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (anyReady) begin
            act_reg   <= grant;
            state_reg <= ST_READ;
          end
        end
        ST_READ: state_reg <= ST_WRITE;
        ST_WRITE: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Bus requests for the read and write phases.
  logic [DW-1:0] ramAddrNow;
  logic [DW-1:0] periphAddrNow;
  always_comb begin
    ramAddrNow = workAddr_reg[act_reg];
    if (ac.addrStyle[1]) begin
      ramAddrNow = primaryBase_reg[act_reg] + periphRdata; // R8
    end
    periphAddrNow = periphAddr_reg[act_reg]; // R15
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ramReq    <= '0;
      periphReq <= '0;
    end else begin
      ramReq    <= '0;
      periphReq <= '0;
      if (state_reg == ST_IDLE && anyReady) begin
        ramReq.valid    <= ctrl_reg[grant].toPeriph;
        ramReq.addr     <= workAddr_reg[grant];
        ramReq.byteSize <= ctrl_reg[grant].byteSize;
        periphReq.valid <= !ctrl_reg[grant].toPeriph;
        periphReq.addr  <= periphAddr_reg[grant];
        periphReq.byteSize <= ctrl_reg[grant].byteSize;
      end else if (state_reg == ST_READ) begin
        if (ac.toPeriph) begin // R5
          periphReq <= '{1'b1, 1'b1, ac.byteSize, periphAddrNow, ramRdata};
        end else begin
          ramReq <= '{1'b1, 1'b1, ac.byteSize, ramAddrNow, periphRdata};
          if (ac.nullWrite) begin
            periphReq <= '{1'b1, 1'b1, ac.byteSize, periphAddrNow, '0}; // R7
          end
        end
      end
    end
  end

  // Register writes, channel progress and automatic state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_reg[c]          <= '0; // R3
        primaryBase_reg[c]   <= '0; // R12
        secondaryBase_reg[c] <= '0;
        periphAddr_reg[c]    <= '0;
        count_reg[c]         <= '0;
        reqSel_reg[c]        <= '0;
        workAddr_reg[c]      <= '0;
        done_reg[c]          <= '0;
      end
      force_reg       <= '0;
      pingSel_reg     <= '0;
      secondBlock_reg <= '0;
    end else begin
      if (finish) begin
        force_reg[act_reg] <= 1'b0; // R10
      end
      if (regWrite && chSpace) begin
        unique case (offOf(regAddr))
          OFF_CON: begin
            ctrl_reg[chOf(regAddr)] <= '{regWdata[B_EN], regWdata[B_SIZE],
              regWdata[B_DIR], regWdata[B_HALF], regWdata[B_NULL],
              regWdata[5:4], regWdata[1:0]}; // R3 R4 R5 R6 R7 R8 R9
            if (regWdata[B_EN] && !ctrl_reg[chOf(regAddr)].enable) begin
              workAddr_reg[chOf(regAddr)] <= primaryBase_reg[chOf(regAddr)];
              done_reg[chOf(regAddr)]     <= '0;
              pingSel_reg[chOf(regAddr)]  <= 1'b0;
              secondBlock_reg[chOf(regAddr)] <= 1'b0;
            end
          end
          OFF_REQ: begin
            reqSel_reg[chOf(regAddr)] <= regWdata[6:0]; // R11
            if (regWdata[B_FORCE]) begin
              force_reg[chOf(regAddr)] <= 1'b1; // R10
            end
          end
          OFF_PRI: primaryBase_reg[chOf(regAddr)] <= regWdata; // R2
          OFF_SEC: secondaryBase_reg[chOf(regAddr)] <= regWdata; // R2
          OFF_PAD: periphAddr_reg[chOf(regAddr)] <= regWdata;
          OFF_COUNT: count_reg[chOf(regAddr)] <= regWdata[9:0];
          default: ;
        endcase
      end
      if (finish) begin
        done_reg[act_reg]  <= done_reg[act_reg] + 10'h001;
        if (ac.addrStyle == AM_POSTINC) begin
          workAddr_reg[act_reg] <= workAddr_reg[act_reg] + stepOf(ac.byteSize);
        end
        if (blockEnd) begin
          done_reg[act_reg] <= '0;
          if (ac.opMode[1]) begin
            pingSel_reg[act_reg] <= !pingSel_reg[act_reg]; // R23
            workAddr_reg[act_reg] <= pingSel_reg[act_reg] ?
              primaryBase_reg[act_reg] : secondaryBase_reg[act_reg];
            secondBlock_reg[act_reg] <= !secondBlock_reg[act_reg];
            if (ac.opMode[0] && secondBlock_reg[act_reg]) begin
              ctrl_reg[act_reg].enable <= 1'b0; // R25 R9
            end
          end else begin
            workAddr_reg[act_reg] <= primaryBase_reg[act_reg]; // R25
            if (ac.opMode[0]) begin
              ctrl_reg[act_reg].enable <= 1'b0; // R25
            end
          end
        end
      end
    end
  end

  // Pending requests from selected lines; a new edge beats the grant clear.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_reg    <= '0;
      irqPrev_reg <= '0;
    end else begin
      irqPrev_reg <= reqNow;
      for (int c = 0; c < NCH; c++) begin
        if (reqNow[c] && !irqPrev_reg[c]) begin
          pend_reg[c] <= 1'b1;
        end else if (state_reg == ST_IDLE && anyReady && grant == 3'(c)) begin
          pend_reg[c] <= 1'b0;
        end
      end
    end
  end

  // Status, collisions and interrupt pulses.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      peripheral_write_collision_reg      <= '0;
      ram_write_collision_reg      <= '0;
      lastCh_reg     <= LAST_NONE; // R18
      recentRam_reg  <= '0; // R20
      channelIrqFlag <= '0;
    end else begin
      channelIrqFlag <= '0;
      if (regWrite && regAddr == OFF_CS0) begin
        peripheral_write_collision_reg <= peripheral_write_collision_reg & regWdata[15:8]; // R16
        ram_write_collision_reg <= ram_write_collision_reg & regWdata[7:0]; // R17
      end
      if (finish) begin
        lastCh_reg <= {1'b0, act_reg}; // R18
        if (!ac.toPeriph) begin
          // The write request still holds the address it wrote.
          recentRam_reg <= ramReq.addr; // R20
        end
        if (ac.toPeriph || ac.nullWrite) begin
          peripheral_write_collision_reg[act_reg] <= periphWriteCollision ||
            (peripheral_write_collision_reg[act_reg] && !(regWrite && regAddr == OFF_CS0 &&
             !regWdata[8 + act_reg])); // R16
        end
        if (!ac.toPeriph) begin
          ram_write_collision_reg[act_reg] <= ramWriteCollision ||
            (ram_write_collision_reg[act_reg] && !(regWrite && regAddr == OFF_CS0 &&
             !regWdata[act_reg])); // R17
        end
        if (ac.halfIrq ? halfPoint : blockEnd) begin
          channelIrqFlag[act_reg] <= 1'b1; // R6 R21
        end
      end else if (state_reg == ST_READ && ac.toPeriph) begin
        recentRam_reg <= workAddr_reg[act_reg]; // R20
      end
    end
  end

  // Read mux; base registers return the working pointer.
  always_comb begin
    rdata_next = '0;
    if (chSpace) begin
      unique case (offOf(regAddr))
        OFF_CON: rdata_next = {ctrl_reg[chOf(regAddr)].enable,
          ctrl_reg[chOf(regAddr)].byteSize, ctrl_reg[chOf(regAddr)].toPeriph,
          ctrl_reg[chOf(regAddr)].halfIrq, ctrl_reg[chOf(regAddr)].nullWrite,
          5'h00, ctrl_reg[chOf(regAddr)].addrStyle, 2'h0,
          ctrl_reg[chOf(regAddr)].opMode};
        OFF_REQ: rdata_next = {force_reg[chOf(regAddr)], 8'h00,
          reqSel_reg[chOf(regAddr)]};
        OFF_PRI, OFF_SEC: rdata_next = workAddr_reg[chOf(regAddr)]; // R2
        OFF_PAD: rdata_next = periphAddr_reg[chOf(regAddr)];
        OFF_COUNT: rdata_next = {6'h00, count_reg[chOf(regAddr)]};
        default: rdata_next = '0;
      endcase
    end else if (regAddr == OFF_CS0) begin
      rdata_next = {peripheral_write_collision_reg, ram_write_collision_reg};
    end else if (regAddr == OFF_CS1) begin
      rdata_next = {4'h0, lastCh_reg, pingSel_reg}; // R19
    end else if (regAddr == OFF_RADR) begin
      rdata_next = recentRam_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRead ? rdata_next : '0;
    end
  end

  // Every check below runs on core_clk and is muted during reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_force_clears: assert property (finish && !forceWr |=> // R10
    !force_reg[$past(act_reg)])
    else $error("force bit not cleared after transfer");
  a_last_channel: assert property (finish |=> // R18
    lastCh_reg == {1'b0, $past(act_reg)})
    else $error("last channel not updated");
  a_grant_lowest: assert property (state_reg == ST_IDLE && ready[0] |=> // R24
    act_reg == 3'h0)
    else $error("channel 0 lost arbitration");
  a_oneshot_stop: assert property (blockEnd && ac.opMode == 2'h1 |=> // R25
    !ctrl_reg[$past(act_reg)].enable)
    else $error("one-shot channel stayed enabled");
  a_pingpong_flip: assert property (blockEnd && ac.opMode[1] |=> // R23
    pingSel_reg[$past(act_reg)] != $past(pingSel_reg[act_reg]))
    else $error("ping-pong select did not toggle");
  a_irq_cause: assert property ($rose(|channelIrqFlag) |-> // R21
    $past(finish))
    else $error("interrupt without a transfer");
  a_xfer_seq: assert property (state_reg == ST_READ |=> // R1
    state_reg == ST_WRITE ##1 state_reg == ST_IDLE)
    else $error("transfer sequence broken");
  a_null_write: assert property ( // R7
    state_reg == ST_READ && !ac.toPeriph && ac.nullWrite |=>
    periphReq.valid && periphReq.write && periphReq.wdata == '0)
    else $error("null peripheral write missing");
  c_block_done: cover property (blockEnd);
  c_half_irq: cover property (halfPoint && ac.halfIrq);
  c_forced: cover property (finish && force_reg[act_reg]);
endmodule // dma_channel_register_set
